// ===== common/rers_pkg.sv
// Constants, register map and pin carrier for the rail enable and reset sequencer.
// Assumes a 125 MHz system clock and 8-bit registers on a plain word port.
package rers_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int DEBOUNCE_MS = 50;
    localparam int RST_DELAY_MS = 100;

    // ------------------------------------------------------------
    // Register indices; the port address is the index itself
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CHG_CFG2 = 8'h04;
    localparam logic [7:0] IDX_CHG_CFG3 = 8'h05;
    localparam logic [7:0] IDX_BUCK = 8'h07;
    localparam logic [7:0] IDX_LINREG = 8'h08;
    localparam logic [7:0] IDX_MISC = 8'h0A;
    localparam logic [7:0] IDX_IO_LEVEL = 8'h0B;
    localparam logic [7:0] IDX_IO_DIR = 8'h0C;
    localparam logic [7:0] IDX_IRQ_MASK0 = 8'h0D;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MISC_MON_SEL = 0;
    localparam int MISC_MON_EN = 1;
    localparam int MISC_HOLD = 5;
    localparam int MISC_BTN_STAT = 7;
    localparam int RAIL_HOLD = 7;
    localparam int CFG2_COMP_EN = 0;
    localparam int CFG2_CHG_EN = 1;
    localparam int CFG3_COMP_STAT = 2;
    localparam int MASK_BATT = 0;

    // ------------------------------------------------------------
    // Reset values and voltage code range (0.8 V to 3.3 V, 50 mV)
    // ------------------------------------------------------------
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG3_RST = 8'h00;
    localparam logic [7:0] IO_LEVEL_RST = 8'h00;
    localparam logic [7:0] IO_DIR_RST = 8'hC0;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [5:0] VSET_MAX = 6'h32;

    typedef struct packed {
        logic button_n;
        logic buck_hold;
        logic linreg_hold;
        logic power_valid;
        logic uvlo;
        logic over_temp;
        logic linreg_pgood;
        logic sense_ok;
        logic batt_below;
        logic charger_active;
        logic [3:0] io_in;
    } rers_pins_t;

endpackage : rers_pkg

// ===== core/rers_top.sv
// Power rail enable, button debounce, reset release and monitor control.
// Assumes pins arrive asynchronously and analog blocks act on the levels driven.
//
// Contract
// RULE1: Button low or charger valid enables both rails.
// RULE2: Button debounced for 50 ms.
// RULE3: Rails start together, stop unless held.
// RULE4: Buck hold pin keeps buck rail on.
// RULE5: Linear hold pin keeps linear rail on.
// RULE6: After first power-up hold pins enable rails.
// RULE7: First power-on after battery loss needs button.
// RULE8: Miscellaneous hold bit keeps both rails on.
// RULE9: Open-drain reset released 100 ms later.
// RULE10: Fixed variant resets on linear rail bad.
// RULE11: Sense variant resets on low sense input.
// RULE12: Registers default on undervoltage or reset.
// RULE13: Voltage codes 0.8-3.3 V; adjustable buck ignores.
// RULE14: Undervoltage disables both rails.
// RULE15: Over-temperature with linear rail stops both.
// RULE16: Monitor select picks battery or thermistor.
// RULE17: Thermistor source on when idle, enabled, temperature.
// RULE18: Monitor disabled ties output to ground.
// RULE19: Primary mode compares battery against selected threshold.
// RULE20: Battery low interrupt only when unmasked.
// RULE21: Disabled comparator status reads one.
// RULE22: I/O 0,1 inputs; 2,3 LED sinks off.
// RULE23: Hold pin ORed with rail hold bit.
// RULE24: Debounce restarts on any level change.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rers_top #(
    parameter int TICK_CYCLES = rers_pkg::TICK_CYCLES,
    parameter bit SENSE_VARIANT = 1'b0,
    parameter bit BUCK_ADJUSTABLE = 1'b0,
    parameter logic [5:0] BUCK_VSET_RST = 6'h14,
    parameter logic [5:0] LINREG_VSET_RST = 6'h14
) (
    input wire logic clk,
    input wire logic rst,
    input wire rers_pkg::rers_pins_t pins,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic buck_rail,
    output logic linreg_rail,
    output logic reset_out,
    output logic reset_oe,
    output logic monitor_select,
    output logic monitor_gnd,
    output logic ntc_source_en,
    output logic [1:0] batt_threshold_sel,
    output logic batt_low_irq,
    output logic [5:0] buck_vset,
    output logic [5:0] linreg_vset,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    output logic [3:0] led_sink_en
);
    import rers_pkg::*;

    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 1_000_000) begin
            $error("rers_top: TICK_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    // Reset to the idle pin levels, so the released button is not seen as pressed.
    localparam rers_pins_t PINS_IDLE = '{button_n: 1'b1, default: '0};
    rers_pins_t sync1_q;
    rers_pins_t pin_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= PINS_IDLE;
            pin_q <= PINS_IDLE;
        end else begin
            sync1_q <= pins;
            pin_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Millisecond timebase
    // ------------------------------------------------------------
    logic [19:0] div_q;
    logic tick_q;
    wire div_end = (div_q == 20'(TICK_CYCLES - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_end ? '0 : div_q + 20'h0_0001;
            tick_q <= div_end;
        end
    end

    // ------------------------------------------------------------
    // Button debounce
    // ------------------------------------------------------------
    // The count restarts on any raw change, so only a level that stays
    // put for the full interval is accepted.
    logic btn_db_q;
    logic [6:0] db_cnt_q;
    wire btn_diff = (pin_q.button_n != btn_db_q);
    wire db_done = tick_q && (db_cnt_q == 7'(DEBOUNCE_MS - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            btn_db_q <= 1'b1;
            db_cnt_q <= '0;
        end else if (!btn_diff) begin
            db_cnt_q <= '0; // RULE24
        end else if (db_done) begin
            btn_db_q <= pin_q.button_n; // RULE2
            db_cnt_q <= '0;
        end else if (tick_q) begin
            db_cnt_q <= db_cnt_q + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] misc_q;
    logic [7:0] cfg2_q;
    logic [7:0] cfg3_q;
    logic [7:0] buck_q;
    logic [7:0] lin_q;
    logic [7:0] io_lvl_q;
    logic [7:0] io_dir_q;
    logic [7:0] mask_q;
    logic comp_stat_q;
    logic reg_clear;

    function automatic logic vset_ok(input logic [7:0] v);
        return v[5:0] <= VSET_MAX;
    endfunction

    wire wr_misc = wr_stb && (addr == IDX_MISC);
    wire wr_cfg2 = wr_stb && (addr == IDX_CHG_CFG2);
    wire wr_cfg3 = wr_stb && (addr == IDX_CHG_CFG3);
    wire wr_buck = wr_stb && (addr == IDX_BUCK) && vset_ok(wdata);
    wire wr_lin = wr_stb && (addr == IDX_LINREG) && vset_ok(wdata);
    wire wr_lvl = wr_stb && (addr == IDX_IO_LEVEL);
    wire wr_dir = wr_stb && (addr == IDX_IO_DIR);
    wire wr_mask = wr_stb && (addr == IDX_IRQ_MASK0);
    wire [7:0] buck_rst = {2'b00, BUCK_VSET_RST};
    wire [7:0] lin_rst = {2'b00, LINREG_VSET_RST};

    // Register defaults come back under undervoltage or while reset is driven.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            misc_q <= MISC_RST;
            cfg2_q <= CFG2_RST;
            cfg3_q <= CFG3_RST;
            io_lvl_q <= IO_LEVEL_RST;
            io_dir_q <= IO_DIR_RST;
            mask_q <= MASK_RST;
        end else if (reg_clear) begin
            misc_q <= MISC_RST; // RULE12
            cfg2_q <= CFG2_RST;
            cfg3_q <= CFG3_RST;
            io_lvl_q <= IO_LEVEL_RST;
            io_dir_q <= IO_DIR_RST; // RULE22
            mask_q <= MASK_RST;
        end else begin
            if (wr_misc) misc_q <= wdata;
            if (wr_cfg2) cfg2_q <= wdata;
            if (wr_cfg3) cfg3_q <= wdata;
            if (wr_lvl) io_lvl_q <= wdata;
            if (wr_dir) io_dir_q <= wdata;
            if (wr_mask) mask_q <= wdata;
        end
    end

    // Out-of-range voltage codes are dropped and the old setting stays.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buck_q <= 8'h00;
            lin_q <= 8'h00;
        end else if (reg_clear) begin
            buck_q <= buck_rst;
            lin_q <= lin_rst;
        end else begin
            if (wr_buck) buck_q <= wdata; // RULE13
            if (wr_lin) lin_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Rail enables
    // ------------------------------------------------------------
    logic buck_q_on;
    logic lin_q_on;
    logic first_up_q;
    wire fault_uv = pin_q.uvlo; // RULE14
    wire fault_ot = pin_q.over_temp && lin_q_on; // RULE15
    wire fault = fault_uv || fault_ot;
    wire start_req = !btn_db_q || pin_q.power_valid; // RULE1
    wire buck_hold = pin_q.buck_hold || buck_q[RAIL_HOLD]; // RULE23
    wire lin_hold = pin_q.linreg_hold || lin_q[RAIL_HOLD];
    wire both_hold = misc_q[MISC_HOLD]; // RULE8
    // Hold pins act as enables once armed by a first start; the arming is
    // lost with the battery, which is why a cold start needs the button or charger valid.
    wire buck_keep = (buck_q_on || first_up_q) && (buck_hold || both_hold);
    wire lin_keep = (lin_q_on || first_up_q) && (lin_hold || both_hold);
    wire buck_d = !fault && (start_req || buck_keep); // RULE3 RULE4 RULE6
    wire lin_d = !fault && (start_req || lin_keep); // RULE3 RULE5 RULE6

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buck_q_on <= 1'b0;
            lin_q_on <= 1'b0;
            first_up_q <= 1'b0;
        end else begin
            buck_q_on <= buck_d;
            lin_q_on <= lin_d;
            if (fault_uv) begin
                first_up_q <= 1'b0; // RULE7
            end else if (start_req) begin
                first_up_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset output
    // ------------------------------------------------------------
    logic rst_oe_q;
    logic [6:0] dly_cnt_q;
    wire fixed_cond = !pin_q.linreg_pgood || !lin_q_on; // RULE10
    wire sense_cond = !pin_q.sense_ok; // RULE11
    wire rst_cond = SENSE_VARIANT ? sense_cond : fixed_cond;
    wire dly_done = tick_q && (dly_cnt_q == 7'(RST_DELAY_MS - 1));
    assign reg_clear = fault_uv || rst_oe_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_oe_q <= 1'b1;
            dly_cnt_q <= '0;
        end else if (rst_cond) begin
            rst_oe_q <= 1'b1;
            dly_cnt_q <= '0;
        end else if (rst_oe_q && dly_done) begin
            rst_oe_q <= 1'b0; // RULE9
        end else if (rst_oe_q && tick_q) begin
            dly_cnt_q <= dly_cnt_q + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Monitor, comparator and I/O
    // ------------------------------------------------------------
    wire mon_sel = misc_q[MISC_MON_SEL];
    wire mon_en = misc_q[MISC_MON_EN];
    wire comp_en = cfg2_q[CFG2_COMP_EN];
    wire primary = !cfg2_q[CFG2_CHG_EN];
    wire comp_live = comp_en && primary;
    wire irq_d = comp_live && pin_q.batt_below && !mask_q[MASK_BATT];
    wire [3:0] dir = io_dir_q[3:0];
    wire [3:0] led = io_dir_q[7:4];
    wire stat_bit = comp_en ? comp_stat_q : 1'b1; // RULE21

    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            IDX_MISC: rd_mux = {btn_db_q, misc_q[6:0]};
            IDX_CHG_CFG2: rd_mux = cfg2_q;
            IDX_CHG_CFG3: rd_mux = {cfg3_q[7:3], stat_bit, cfg3_q[1:0]};
            IDX_BUCK: rd_mux = buck_q;
            IDX_LINREG: rd_mux = lin_q;
            IDX_IO_LEVEL: rd_mux = {io_lvl_q[7:4], pin_q.io_in};
            IDX_IO_DIR: rd_mux = io_dir_q;
            IDX_IRQ_MASK0: rd_mux = mask_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            comp_stat_q <= 1'b0;
            rdata <= 8'h00;
        end else begin
            if (comp_live) comp_stat_q <= !pin_q.batt_below; // RULE19
            rdata <= rd_stb ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buck_rail <= 1'b0;
            linreg_rail <= 1'b0;
            reset_out <= 1'b0;
            reset_oe <= 1'b1;
            monitor_select <= 1'b0;
            monitor_gnd <= 1'b1;
            ntc_source_en <= 1'b0;
            batt_threshold_sel <= 2'b00;
            batt_low_irq <= 1'b0;
        end else begin
            buck_rail <= buck_d;
            linreg_rail <= lin_d;
            reset_out <= 1'b0;
            reset_oe <= rst_cond || (rst_oe_q && !dly_done);
            monitor_select <= mon_sel; // RULE16
            monitor_gnd <= !mon_en; // RULE18
            ntc_source_en <= !pin_q.charger_active && mon_en && mon_sel; // RULE17
            batt_threshold_sel <= cfg3_q[1:0];
            batt_low_irq <= irq_d; // RULE20
        end
    end

    // Register voltage codes drive only rails that honour them; an adjustable buck gets BUCK_VSET_RST.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buck_vset <= 6'h00;
            linreg_vset <= 6'h00;
            io_out <= 4'h0;
            io_oe <= 4'h0;
            led_sink_en <= 4'h0;
        end else begin
            buck_vset <= BUCK_ADJUSTABLE ? BUCK_VSET_RST : buck_q[5:0]; // RULE13
            linreg_vset <= lin_q[5:0];
            io_out <= io_lvl_q[3:0];
            io_oe <= dir & ~led;
            led_sink_en <= dir & led & io_lvl_q[3:0]; // RULE22
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_reset_counted;
        rst_oe_q && !rst_cond && dly_done;
    endsequence

    a_uvlo_rails_off: assert property (fault_uv |=> !buck_rail && !linreg_rail) // RULE14
        else $error("rail on during undervoltage");
    a_thermal_both_off: assert property (fault_ot |=> !buck_rail && !linreg_rail) // RULE15
        else $error("rail on after thermal shutdown");
    a_start_both_rails: assert property (start_req && !fault |=> buck_rail && linreg_rail) // RULE1
        else $error("rails not started together");
    a_buck_hold_kept: assert property (buck_q_on && buck_hold && !fault |=> buck_rail) // RULE4
        else $error("buck rail dropped while held");
    a_lin_hold_kept: assert property (lin_q_on && lin_hold && !fault |=> linreg_rail) // RULE5
        else $error("linear rail dropped while held");
    a_release_off: assert property (!start_req && !both_hold && !buck_hold && !fault
        |=> !buck_rail) // RULE3
        else $error("buck rail on without request or hold");
    a_debounce_time: assert property ($changed(btn_db_q)
        |-> $past(db_cnt_q) == 7'(DEBOUNCE_MS - 1) && $past(tick_q)) // RULE2
        else $error("button accepted before debounce time");
    a_reset_assert: assert property (rst_cond |=> reset_oe && !reset_out) // RULE9
        else $error("reset not driven low");
    a_reset_release: assert property ($fell(reset_oe)
        |-> $past(rst_oe_q && !rst_cond && dly_done)) // RULE9
        else $error("reset released without full delay");
    a_reset_counted: assert property (s_reset_counted |=> !reset_oe && !rst_oe_q) // RULE9
        else $error("reset held after full delay");
    a_reg_defaults: assert property (rst_oe_q |=> misc_q == MISC_RST && io_dir_q == IO_DIR_RST) // RULE12
        else $error("registers not at default under reset");
    a_comp_reads_one: assert property (rd_stb && addr == IDX_CHG_CFG3 && !comp_en
        |=> rdata[CFG3_COMP_STAT]) // RULE21
        else $error("disabled comparator status not one");
    a_irq_masked: assert property (mask_q[MASK_BATT] |=> !batt_low_irq) // RULE20
        else $error("masked battery interrupt raised");
    a_monitor_ground: assert property (!mon_en |=> monitor_gnd && !ntc_source_en) // RULE18
        else $error("monitor output not grounded");

endmodule : rers_top

`default_nettype wire

// ===== tb/rers_far_side.sv
// Far-side model: the load on the linear rail and the pulled-up reset wire.
// Assumes the rail enable and the open-drain reset controls of rers_top.
`timescale 1ns/1ps
`default_nettype none

module rers_far_side (
    input wire logic clk,
    input wire logic rst,
    input wire logic linreg_rail,
    input wire logic reset_out,
    input wire logic reset_oe,
    output logic linreg_pgood,
    output logic reset_pin
);
    logic [1:0] ramp_q;

    // ------------------------------------------------------------
    // Rail output and reset wire
    // ------------------------------------------------------------
    // The output settles two cycles after enable and collapses at once when disabled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ramp_q <= 2'b00;
        end else begin
            ramp_q <= linreg_rail ? {ramp_q[0], 1'b1} : 2'b00;
        end
    end
    assign linreg_pgood = ramp_q[1] & linreg_rail;
    // The pull-up wins whenever the device lets go of the wire.
    assign reset_pin = reset_oe ? reset_out : 1'b1;
endmodule : rers_far_side

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for rers_top with a shortened millisecond tick.
// Assumes rers_pkg and the far-side model rers_far_side.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rers_pkg::*;
    localparam int TICK = 10;
    typedef struct packed {
        logic chg;
        logic [7:0] misc;
        logic [2:0] mon;
    } rers_row_t;
    rers_row_t rows [5] = '{'{1'b0, 8'h00, 3'b010}, '{1'b0, 8'h01, 3'b110},
        '{1'b0, 8'h03, 3'b101}, '{1'b1, 8'h03, 3'b100}, '{1'b0, 8'h02, 3'b000}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    rers_pins_t pins = '{button_n: 1'b1, default: '0};
    rers_pins_t pins_dut;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    logic buck_rail, linreg_rail, reset_out, reset_oe, reset_pin, pgood;
    logic monitor_select, monitor_gnd, ntc_source_en, batt_low_irq, seen, s_oe;
    logic [1:0] batt_threshold_sel;
    logic [5:0] linreg_vset, buck_vset;
    logic [3:0] io_oe, led_sink_en, io_out;
    logic [1:0] rails;
    logic [7:0] rd_val;
    int fail_count = 0;
    int n_tests = 0;

    always #4 clk = ~clk;
    assign rails = {buck_rail, linreg_rail};
    always_comb begin
        pins_dut = pins;
        pins_dut.linreg_pgood = pgood;
    end

    rers_top #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .rst(rst), .pins(pins_dut),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .buck_rail(buck_rail), .linreg_rail(linreg_rail), .reset_out(reset_out),
        .reset_oe(reset_oe), .monitor_select(monitor_select), .monitor_gnd(monitor_gnd),
        .ntc_source_en(ntc_source_en), .batt_threshold_sel(batt_threshold_sel),
        .batt_low_irq(batt_low_irq), .buck_vset(buck_vset), .linreg_vset(linreg_vset),
        .io_out(io_out), .io_oe(io_oe), .led_sink_en(led_sink_en));

    // The sense-input variant shares all stimulus; only its reset drive is watched.
    rers_top #(.TICK_CYCLES(TICK), .SENSE_VARIANT(1'b1)) u_dut_sense (.clk(clk), .rst(rst),
        .pins(pins_dut), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(), .buck_rail(), .linreg_rail(), .reset_out(), .reset_oe(s_oe),
        .monitor_select(), .monitor_gnd(), .ntc_source_en(), .batt_threshold_sel(),
        .batt_low_irq(), .buck_vset(), .linreg_vset(), .io_out(), .io_oe(), .led_sink_en());

    rers_far_side u_far (.clk(clk), .rst(rst), .linreg_rail(linreg_rail),
        .reset_out(reset_out), .reset_oe(reset_oe), .linreg_pgood(pgood),
        .reset_pin(reset_pin));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    // Pin changes need two sync flops and one register stage before the rails move.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk(8'({rails, reset_oe, reset_pin, monitor_gnd, reset_out}), 8'h0A);
        chk(8'({io_oe, led_sink_en}), 8'h00);
        chk(8'(s_oe), 8'h01);
        rd(IDX_IO_DIR);
        chk(rd_val, IO_DIR_RST);
        rd(IDX_IRQ_MASK0);
        chk(rd_val, MASK_RST);
        pins.button_n <= 1'b0;
        pins.sense_ok <= 1'b1;
        settle(30 * TICK);
        pins.button_n <= 1'b1;
        settle(60 * TICK);
        chk(8'(rails), 8'h00);
        chk(8'(s_oe), 8'h01);
        pins.button_n <= 1'b0;
        settle(45 * TICK);
        chk(8'(rails), 8'h00);
        chk(8'(s_oe), 8'h00);
        settle(10 * TICK);
        chk(8'(rails), 8'h03);
        settle(90 * TICK);
        chk(8'(reset_pin), 8'h00);
        settle(20 * TICK);
        chk(8'(reset_pin), 8'h01);
        done("power_on");
        foreach (rows[i]) begin
            @(posedge clk);
            pins.charger_active <= rows[i].chg;
            wr(IDX_MISC, rows[i].misc);
            settle(4);
            chk(8'({monitor_select, monitor_gnd, ntc_source_en}), 8'(rows[i].mon));
            rd(IDX_MISC);
            chk(rd_val & 8'h7F, rows[i].misc);
        end
        done("monitor");
        rd(IDX_CHG_CFG3);
        chk(rd_val & 8'h04, 8'h04);
        pins.batt_below <= 1'b1;
        wr(IDX_CHG_CFG3, 8'h02);
        wr(IDX_CHG_CFG2, 8'h01);
        settle(4);
        rd(IDX_CHG_CFG3);
        chk(rd_val & 8'h07, 8'h02);
        chk(8'({batt_threshold_sel, batt_low_irq}), 8'h04);
        wr(IDX_IRQ_MASK0, 8'hFE);
        settle(3);
        chk(8'(batt_low_irq), 8'h01);
        wr(IDX_CHG_CFG2, 8'h03);
        settle(3);
        chk(8'(batt_low_irq), 8'h00);
        done("comparator");
        wr(IDX_LINREG, 8'h32);
        wr(IDX_LINREG, 8'h33);
        rd(IDX_LINREG);
        chk(rd_val, 8'h32);
        chk(8'(linreg_vset), 8'h32);
        wr(IDX_BUCK, 8'h05);
        wr(IDX_IO_LEVEL, 8'h0F);
        wr(IDX_IO_DIR, 8'hCF);
        pins.io_in <= 4'h5;
        settle(4);
        chk(8'(buck_vset), 8'h05);
        chk(8'({io_oe, led_sink_en}), 8'h3C);
        chk(8'(io_out), 8'h0F);
        rd(IDX_IO_LEVEL);
        chk(rd_val, 8'h05);
        done("voltage");
        pins.buck_hold <= 1'b1;
        pins.button_n <= 1'b1;
        settle(55 * TICK);
        chk(8'({rails, reset_oe}), 8'h05);
        rd(IDX_LINREG);
        chk(rd_val, 8'h14);
        rd(IDX_MISC);
        chk(rd_val & 8'h7F, MISC_RST);
        pins.linreg_hold <= 1'b1;
        settle(5);
        chk(8'(rails), 8'h03);
        settle(110 * TICK);
        chk(8'(reset_oe), 8'h00);
        wr(IDX_MISC, 8'h20);
        pins.buck_hold <= 1'b0;
        pins.linreg_hold <= 1'b0;
        settle(5);
        chk(8'(rails), 8'h03);
        wr(IDX_LINREG, 8'h94);
        wr(IDX_MISC, 8'h00);
        settle(5);
        chk(8'(rails), 8'h01);
        done("hold");
        pins.over_temp <= 1'b1;
        seen = 1'b0;
        repeat (6) begin
            settle(1);
            if (rails === 2'b00) seen = 1'b1;
        end
        chk(8'(seen), 8'h01);
        pins.over_temp <= 1'b0;
        settle(200);
        pins.linreg_hold <= 1'b1;
        settle(5);
        chk(8'(rails), 8'h01);
        pins.uvlo <= 1'b1;
        pins.sense_ok <= 1'b0;
        settle(5);
        chk(8'(rails), 8'h00);
        chk(8'(s_oe), 8'h01);
        pins.uvlo <= 1'b0;
        settle(5);
        chk(8'(rails), 8'h00);
        pins.power_valid <= 1'b1;
        settle(5);
        chk(8'(rails), 8'h03);
        done("faults");
        conclude();
    end
endmodule : testbench

`default_nettype wire
